// ---- core/csc_sideband_ctrl.sv ----
// Purpose: Sideband control of an embedded processor: management mode flag,
//   soft reset, stop-clock handshake, reset straps and cycle definition.
// Assumes: 100 MHz ref_clk; rst_n is power-on reset; the processor core
//   talks over same-clock strobes; bus ready pins are synchronous.
// Notes: Straps are caught while the hard reset pin is high, so the last
//   value caught is the one from the clock before its falling edge.
// Contract
// - Management-active output goes low on entry, high on hard reset or resume.
// - Management-active output stays driven through bus hold and backoff.
// - Soft reset pin is sampled on every rising clock edge.
// - Sampled soft reset starts its sequence at the next instruction boundary.
// - Soft reset keeps cache controls, base pointer and straps untouched.
// - Stop-clock request halts at boundary unless higher interrupt is pending.
// - After halting, drain pipelines and write buffers, then issue stop-grant.
// - Upgrade-present sampled before hard reset falls; low floats all outputs (voltage detect stays driven low here).
// - Device stays floated only while upgrade-present remains asserted.
// - Cache-policy strap sampled at hard reset; low makes fills write-through.
// - Write-read indicator is high for writes and low for reads.
// - Voltage-detect output is constantly low.
// - Falling management request enters management mode at a boundary, below soft reset.
// - Stop-grant cycle: io, code, write, address 10h, byte enables 1011.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "csc_cfg.svh"

module csc_sideband_ctrl #(
  parameter logic [31:0] MGMT_BASE_DEFAULT = 32'h0000_0000
) (
  input wire logic ref_clk, // System clock, 100 MHz.
  input wire logic rst_n, // Power-on reset, async, active low.
  input wire logic hard_reset_in, // Hard reset pin, async, active high.
  input wire logic soft_reset_in, // Soft reset pin, async, active high.
  input wire logic stop_clock_request_n, // Stop-clock request pin, active low.
  input wire logic sysmgmt_request_n, // Management request pin, falling edge.
  input wire logic upgrade_present_n, // Upgrade-present strap, active low.
  input wire logic cache_policy_strap, // Cache-policy strap, low is write-through.
  input wire logic rdy_n, // Non-burst ready, synchronous.
  input wire logic burst_ready_n, // Burst ready, synchronous.
  input wire logic backoff_n, // Bus backoff, synchronous, active low.
  input wire logic hold_ack, // Core has granted the bus to another master.
  input wire logic instr_boundary, // Core is at an instruction boundary.
  input wire logic irq_pending, // Core has an unmasked NMI or INTR pending.
  input wire logic rsm_exec, // Core executed the resume-from-management op.
  input wire logic drain_done, // Core pipelines and write buffers are empty.
  input wire logic core_cyc_start, // Core requests a bus cycle.
  input wire csc_pkg::csc_cycle_type core_cyc, // Cycle definition from the core.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [31:0] reg_rdata, // Read data, cycle after the strobe.
  output logic smm_active_n, // Management mode active, low.
  output logic smm_active_oe, // Output enable of smm_active_n.
  output logic voltage_detect_out, // Voltage detect, constant low.
  output csc_pkg::csc_cycle_type bus_cyc, // Cycle definition pins.
  output logic addr_strobe_n, // Address strobe, one cycle low.
  output logic bus_oe, // Output enable of the bus pins.
  output logic core_cyc_done, // Pulse: core cycle finished.
  output logic core_soft_reset, // Pulse: start soft reset in the core.
  output logic core_smm_entry, // Pulse: enter management mode.
  output logic core_halt, // Level: core must stop executing.
  output logic core_resume, // Pulse: leave stop-grant, resume execution.
  output logic core_inactive, // Level: upgrade present, core kept idle.
  output logic stop_grant_state, // Level: in the stop-grant state.
  output logic fill_write_through, // Level: all line fills are write-through.
  output logic cache_disable_bit, // Cache disable control bit.
  output logic no_writethrough_bit, // No-write-through control bit.
  output logic [31:0] mgmt_base_pointer // Management base pointer.
);

  logic [`CSC_SYN_W-1:0] pin_raw;
  logic [`CSC_SYN_W-1:0] pin_lvl;
  logic hard_reset;
  logic soft_reset_in_lvl;
  logic soft_reset_in_prev;
  logic stp_active;
  logic smi_prev;
  logic smi_fall;
  logic soft_reset_in_pend;
  logic smi_pend;
  logic up_low_latched;
  logic next_idle;
  logic take;
  logic do_soft_reset_in;
  logic do_smi;
  logic do_stop;
  logic bus_busy;
  logic sg_cycle;
  logic rerun;
  logic launch;
  logic bus_ready;
  csc_pkg::csc_stop_state_type state;
  csc_pkg::csc_stop_state_type next_state;

  assign pin_raw = {cache_policy_strap, upgrade_present_n, sysmgmt_request_n,
                    stop_clock_request_n, soft_reset_in, hard_reset_in};

  // Every asynchronous pin is sampled each rising edge and filtered here.
  csc_sync3 #(
    .W(`CSC_SYN_W),
    .RST_VAL(`CSC_SYN_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(pin_raw),
    .level_out(pin_lvl)
  );

  assign hard_reset = pin_lvl[`CSC_SYN_HRST];
  assign soft_reset_in_lvl = pin_lvl[`CSC_SYN_SRST];
  assign stp_active = ~pin_lvl[`CSC_SYN_STP];
  assign smi_fall = smi_prev & ~pin_lvl[`CSC_SYN_SMI];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smi_prev <= 1'b1;
      soft_reset_in_prev <= 1'b0;
    end else begin
      smi_prev <= pin_lvl[`CSC_SYN_SMI];
      soft_reset_in_prev <= soft_reset_in_lvl;
    end
  end

  // Straps follow the pins while hard reset is high, then freeze. Soft reset
  // never reaches this process, so it cannot resample them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_low_latched <= 1'b0;
      fill_write_through <= 1'b1;
    end else if (hard_reset) begin
      up_low_latched <= ~pin_lvl[`CSC_SYN_UP];
      fill_write_through <= ~pin_lvl[`CSC_SYN_WBWT];
    end
  end

  // The device idles only while the strap was caught low and still is low.
  assign next_idle = up_low_latched & ~hard_reset & ~pin_lvl[`CSC_SYN_UP];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_inactive <= 1'b0;
      bus_oe <= 1'b0;
      smm_active_oe <= 1'b1;
    end else begin
      core_inactive <= next_idle;
      bus_oe <= ~next_idle & ~hold_ack & backoff_n;
      // Hold and backoff have no say over this pin; only the upgrade idle does.
      smm_active_oe <= ~next_idle;
    end
  end

  // Boundary arbitration: soft reset, then management request, then the
  // core's own interrupts, and stop-clock last.
  assign take = instr_boundary & ~core_inactive & ~hard_reset & (state == csc_pkg::st_run);
  assign do_soft_reset_in = take & soft_reset_in_pend;
  assign do_smi = take & ~soft_reset_in_pend & smi_pend;
  assign do_stop = take & ~soft_reset_in_pend & ~smi_pend & ~irq_pending & stp_active;

  // A request arriving as its flag is cleared sets it again.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_in_pend <= 1'b0;
    end else if (hard_reset) begin
      soft_reset_in_pend <= 1'b0;
    end else begin
      soft_reset_in_pend <= (soft_reset_in_pend & ~do_soft_reset_in) | (soft_reset_in_lvl & ~soft_reset_in_prev);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smi_pend <= 1'b0;
    end else if (hard_reset) begin
      smi_pend <= 1'b0;
    end else begin
      smi_pend <= (smi_pend & ~do_smi) | (smi_fall & smm_active_n);
    end
  end

  // Management-active flag; soft reset leaves it alone by design.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smm_active_n <= 1'b1;
    end else if (hard_reset) begin
      smm_active_n <= 1'b1;
    end else if (do_smi) begin
      smm_active_n <= 1'b0;
    end else if (rsm_exec) begin
      smm_active_n <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_soft_reset <= 1'b0;
      core_smm_entry <= 1'b0;
    end else begin
      core_soft_reset <= do_soft_reset_in;
      core_smm_entry <= do_smi;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      csc_pkg::st_run: begin
        if (do_stop) begin
          next_state = csc_pkg::st_halt;
        end
      end
      csc_pkg::st_halt: begin
        if (drain_done && !bus_busy) begin
          next_state = csc_pkg::st_issue;
        end
      end
      csc_pkg::st_issue: begin
        next_state = csc_pkg::st_wait_rdy;
      end
      csc_pkg::st_wait_rdy: begin
        // The request is expected to stay low until this ready arrives.
        if (bus_ready) begin
          next_state = csc_pkg::st_grant;
        end
      end
      csc_pkg::st_grant: begin
        if (!stp_active) begin
          next_state = csc_pkg::st_run;
        end
      end
    endcase
    if (hard_reset) begin
      next_state = csc_pkg::st_run;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= csc_pkg::st_run;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_halt <= 1'b0;
      stop_grant_state <= 1'b0;
      core_resume <= 1'b0;
    end else begin
      core_halt <= (next_state != csc_pkg::st_run);
      stop_grant_state <= (next_state == csc_pkg::st_grant);
      core_resume <= (state == csc_pkg::st_grant) && (next_state == csc_pkg::st_run);
    end
  end

  // Bus cycle engine. Ready is ignored in the strobe cycle and during
  // backoff; a backed-off cycle is strobed again once backoff lifts.
  assign launch = (core_cyc_start & ~bus_busy & (state == csc_pkg::st_run) & ~core_inactive)
                | (state == csc_pkg::st_issue);
  assign bus_ready = bus_busy & addr_strobe_n & backoff_n & ~rerun
                   & (~rdy_n | ~burst_ready_n);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy <= 1'b0;
      sg_cycle <= 1'b0;
    end else if (hard_reset) begin
      bus_busy <= 1'b0;
      sg_cycle <= 1'b0;
    end else if (launch) begin
      bus_busy <= 1'b1;
      sg_cycle <= (state == csc_pkg::st_issue);
    end else if (bus_ready) begin
      bus_busy <= 1'b0;
      sg_cycle <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rerun <= 1'b0;
    end else if (hard_reset || launch) begin
      rerun <= 1'b0;
    end else if (bus_busy && !backoff_n) begin
      rerun <= 1'b1;
    end else if (backoff_n) begin
      rerun <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_strobe_n <= 1'b1;
    end else begin
      addr_strobe_n <= ~(launch | (rerun & backoff_n & bus_busy & ~hard_reset));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_cyc <= '0;
    end else if (launch && state == csc_pkg::st_issue) begin
      bus_cyc.addr <= `CSC_SG_ADDR;
      bus_cyc.be_n <= `CSC_SG_BE_N;
      bus_cyc.mem_io <= `CSC_SG_MIO;
      bus_cyc.data_code <= `CSC_SG_DC;
      bus_cyc.write_read <= `CSC_SG_WR;
    end else if (launch) begin
      bus_cyc <= core_cyc;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_cyc_done <= 1'b0;
    end else begin
      core_cyc_done <= bus_ready & ~sg_cycle;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      voltage_detect_out <= 1'b0;
    end else begin
      voltage_detect_out <= 1'b0;
    end
  end

  // Cache controls and base pointer: only power-on reset and hard reset restore them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_disable_bit <= 1'b1;
      no_writethrough_bit <= 1'b1;
    end else if (hard_reset) begin
      cache_disable_bit <= 1'b1;
      no_writethrough_bit <= 1'b1;
    end else if (reg_wr && reg_addr == `CSC_OFS_CTRL) begin
      cache_disable_bit <= reg_wdata[`CSC_CTRL_CD];
      no_writethrough_bit <= reg_wdata[`CSC_CTRL_NW];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_base_pointer <= MGMT_BASE_DEFAULT;
    end else if (hard_reset) begin
      mgmt_base_pointer <= MGMT_BASE_DEFAULT;
    end else if (reg_wr && reg_addr == `CSC_OFS_BASE) begin
      mgmt_base_pointer <= reg_wdata;
    end
  end

  function automatic logic [31:0] reg_read(input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      `CSC_OFS_CTRL: begin
        v[`CSC_CTRL_CD] = cache_disable_bit;
        v[`CSC_CTRL_NW] = no_writethrough_bit;
      end
      `CSC_OFS_BASE: begin
        v = mgmt_base_pointer;
      end
      `CSC_OFS_STATUS: begin
        v[`CSC_ST_SMM] = ~smm_active_n;
        v[`CSC_ST_GRANT] = stop_grant_state;
        v[`CSC_ST_SRPEND] = soft_reset_in_pend;
        v[`CSC_ST_WT] = fill_write_through;
        v[`CSC_ST_IDLE] = core_inactive;
        v[`CSC_ST_HALT] = core_halt;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction : reg_read

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= reg_read(reg_addr);
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : csc_sideband_ctrl

// ---- common/csc_cfg.svh ----
// Purpose: Constants for the processor sideband control block.
// Assumes: Included by bare name by the design files.
// Notes: Register offsets sit here too.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

// Register byte offsets on the plain register port.
`define CSC_OFS_CTRL 8'h00
`define CSC_OFS_BASE 8'h04
`define CSC_OFS_STATUS 8'h08

// Control register fields and reset value.
`define CSC_CTRL_CD 0
`define CSC_CTRL_NW 1
`define CSC_CTRL_RST 2'h3

// Status register fields.
`define CSC_ST_SMM 0
`define CSC_ST_GRANT 1
`define CSC_ST_SRPEND 2
`define CSC_ST_WT 3
`define CSC_ST_IDLE 4
`define CSC_ST_HALT 5

// Stop-grant special cycle definition.
`define CSC_SG_ADDR 32'h0000_0010
`define CSC_SG_BE_N 4'hB
`define CSC_SG_MIO 1'h0
`define CSC_SG_DC 1'h0
`define CSC_SG_WR 1'h1

// Bit positions in the synchroniser vector.
`define CSC_SYN_HRST 0
`define CSC_SYN_SRST 1
`define CSC_SYN_STP 2
`define CSC_SYN_SMI 3
`define CSC_SYN_UP 4
`define CSC_SYN_WBWT 5
`define CSC_SYN_W 6
`define CSC_SYN_RST 6'h1D

`endif

// ---- common/csc_pkg.sv ----
// Purpose: Types shared by the sideband control block.
// Assumes: Nothing beyond the constants header.
// Notes: Cycle definition travels as one packed struct.
package csc_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] be_n;
    logic mem_io;
    logic data_code;
    logic write_read;
  } csc_cycle_type;

  typedef enum logic [2:0] {
    st_run,
    st_halt,
    st_issue,
    st_wait_rdy,
    st_grant
  } csc_stop_state_type;

endpackage : csc_pkg

// ---- core/csc_sync3.sv ----
// Purpose: Three-stage synchroniser with agreement filter for async pins.
// Assumes: One clock; rst_n asynchronous, active low.
// Notes: A change counts only once stages two and three agree.
`timescale 1ns/1ps
`include "csc_cfg.svh"

module csc_sync3 #(
  parameter int W = `CSC_SYN_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk, // Clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] async_in, // Raw pin levels.
  output logic [W-1:0] level_out // Filtered synchronous levels.
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // Stage one feeds only stage two, so metastability cannot spread.
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[g] <= RST_VAL[g];
          stage2[g] <= RST_VAL[g];
          stage3[g] <= RST_VAL[g];
          level_out[g] <= RST_VAL[g];
        end else begin
          stage1[g] <= async_in[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          if (stage2[g] == stage3[g]) begin
            level_out[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

endmodule : csc_sync3

// ---- dv/csc_sideband_ctrl_asserts.sv ----
// Purpose: Concurrent checks on the ports of the sideband control block.
// Assumes: One clock domain; rst_n asynchronous, active low.
// Notes: A quiet counter masks the hard reset sync latency.
`timescale 1ns/1ps

module csc_sideband_ctrl_asserts (
  input wire logic ref_clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic hard_reset_in, // Hard reset pin.
  input wire logic instr_boundary, // Core boundary.
  input wire logic irq_pending, // Core interrupt pending.
  input wire logic rsm_exec, // Resume executed.
  input wire logic drain_done, // Core drained.
  input wire logic smm_active_n, // Mode flag, low active.
  input wire logic smm_active_oe, // Mode flag enable.
  input wire logic voltage_detect_out, // Voltage detect.
  input wire csc_pkg::csc_cycle_type bus_cyc, // Cycle definition.
  input wire logic addr_strobe_n, // Address strobe.
  input wire logic bus_oe, // Bus enable.
  input wire logic core_soft_reset, // Soft reset pulse.
  input wire logic core_smm_entry, // Entry pulse.
  input wire logic core_halt, // Halt level.
  input wire logic core_inactive // Upgrade idle.
);
  logic [2:0] hr_cnt;
  logic hr_quiet;
  // Masks the sync delay of the hard reset pin.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) hr_cnt <= 3'h0;
    else if (hard_reset_in) hr_cnt <= 3'h0;
    else if (hr_cnt != 3'h7) hr_cnt <= hr_cnt + 3'h1;
  end
  assign hr_quiet = (hr_cnt == 3'h7);

  default clocking dc_u @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_vd; voltage_detect_out == 1'h0; endproperty
  a_vd: assert property (p_vd) else $error("voltage detect not low");
  property p_entry; core_smm_entry |-> !smm_active_n; endproperty
  a_entry: assert property (p_entry) else $error("flag not low on entry");
  property p_hold; !smm_active_n && !rsm_exec && hr_quiet |=> !smm_active_n; endproperty
  a_hold: assert property (p_hold) else $error("flag rose early");
  property p_rise; $rose(smm_active_n) |-> $past(rsm_exec) || !hr_quiet; endproperty
  a_rise: assert property (p_rise) else $error("flag rose without cause");
  property p_oe; smm_active_oe || core_inactive || $past(core_inactive); endproperty
  a_oe: assert property (p_oe) else $error("flag not driven");
  property p_float; core_inactive && $past(core_inactive) |-> !bus_oe && !smm_active_oe;
  endproperty
  a_float: assert property (p_float) else $error("outputs driven while idle");
  property p_mbnd; $rose(core_smm_entry) |-> $past(instr_boundary); endproperty
  a_mbnd: assert property (p_mbnd) else $error("entry off boundary");
  property p_sbnd; $rose(core_soft_reset) |-> $past(instr_boundary); endproperty
  a_sbnd: assert property (p_sbnd) else $error("soft reset off boundary");
  property p_halt; $rose(core_halt) |-> $past(instr_boundary) && !$past(irq_pending);
  endproperty
  a_halt: assert property (p_halt) else $error("bad halt");
  property p_grant; !addr_strobe_n && core_halt |-> bus_cyc == {32'h0000_0010, 4'hB, 3'h1};
  endproperty
  a_grant: assert property (p_grant) else $error("bad stop grant cycle");
  property p_drain; $fell(addr_strobe_n) && core_halt |-> $past(drain_done); endproperty
  a_drain: assert property (p_drain) else $error("grant before drain");
endmodule : csc_sideband_ctrl_asserts

bind csc_sideband_ctrl csc_sideband_ctrl_asserts chk_u (.*);

// ---- dv/csc_chipset_model.sv ----
// Purpose: Chipset model: answers bus cycles and runs the stop-clock request.
// Assumes: Same clock as the block; ready lines are driven high when not answering.
// Notes: Stop request released only after grant ready.
`timescale 1ns/1ps

module csc_chipset_model (
  input wire logic ref_clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic addr_strobe_n, // Cycle start.
  input wire csc_pkg::csc_cycle_type bus_cyc, // Cycle definition.
  input wire logic [3:0] dly, // Wait states minus one.
  input wire logic use_burst, // Answer with burst ready.
  input wire logic stp_go, // Pulse: request a stop.
  output logic rdy_n, // Non-burst ready.
  output logic burst_ready_n, // Burst ready.
  output logic stop_clock_request_n // Stop request.
);
  logic [4:0] cnt;
  logic sg_rdy;
  logic [2:0] gap;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h0;
      rdy_n <= 1'h1;
      burst_ready_n <= 1'h1;
    end else begin
      rdy_n <= 1'h1;
      burst_ready_n <= 1'h1;
      if (!addr_strobe_n) cnt <= {1'h0, dly} + 5'h1;
      else if (cnt == 5'h1) begin
        rdy_n <= use_burst;
        burst_ready_n <= !use_burst;
        cnt <= 5'h0;
      end else if (cnt != 5'h0) cnt <= cnt - 5'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_clock_request_n <= 1'h1;
      gap <= 3'h0;
      sg_rdy <= 1'h0;
    end else begin
      sg_rdy <= (cnt == 5'h1) && (bus_cyc.addr == 32'h0000_0010) && (bus_cyc.be_n == 4'hB);
      if (sg_rdy) begin
        stop_clock_request_n <= 1'h1;
        gap <= 3'h5;
      end else if (gap != 3'h0) gap <= gap - 3'h1;
      else if (stp_go) stop_clock_request_n <= 1'h0;
    end
  end
endmodule : csc_chipset_model

// ---- dv/csc_sideband_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for the sideband control block.
// Assumes: Strap held low outside the strap scenario.
// Notes: Outputs are sampled 1 ns after the edge.
`timescale 1ns/1ps

module csc_sideband_ctrl_tb_top;
  logic ref_clk = 0, rst_n = 0, hard_reset_in = 1, soft_reset_in = 0, sysmgmt_request_n = 1;
  logic upgrade_present_n = 1, cache_policy_strap = 0, backoff_n = 1, hold_ack = 0;
  logic instr_boundary = 0, irq_pending = 0, rsm_exec = 0, drain_done = 0, core_cyc_start = 0;
  logic reg_wr = 0, reg_rd = 0, use_burst = 0, stp_go = 0;
  logic [3:0] dly = 4'h2;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mgmt_base_pointer, rd;
  csc_pkg::csc_cycle_type core_cyc = '0, bus_cyc;
  logic rdy_n, burst_ready_n, stop_clock_request_n, smm_active_n, smm_active_oe;
  logic voltage_detect_out, addr_strobe_n, bus_oe, core_cyc_done, core_soft_reset;
  logic core_smm_entry, core_halt, core_resume, core_inactive, stop_grant_state;
  logic fill_write_through, cache_disable_bit, no_writethrough_bit;
  int n_mismatch = 0, tests_run = 0;

  csc_sideband_ctrl dut_u (.*);

  csc_chipset_model cs_u (.*);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  function automatic bit cond(input int s);
    case (s)
      0: return core_halt === 1'h1;
      1: return stop_grant_state === 1'h1;
      2: return core_halt === 1'h0;
      3: return addr_strobe_n === 1'h0;
      default: return core_cyc_done === 1'h1;
    endcase
  endfunction : cond

  task automatic wait_for(input int s);
    for (int i = 0; i < 200 && !cond(s); i++) cyc(1);
    if (!cond(s)) begin
      n_mismatch++;
      $display("unexpected wait %0d expected 1 seen 0", s);
      end_of_test();
    end
  endtask : wait_for

  task automatic bnd();
    @(posedge ref_clk) instr_boundary <= 1'h1;
    @(posedge ref_clk) instr_boundary <= 1'h0;
    #1;
  endtask : bnd

  task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk) reg_wr <= 1'h0;
  endtask : reg_w

  task automatic reg_r(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk) reg_rd <= 1'h0;
    #1 rd = reg_rdata;
  endtask : reg_r

  task automatic hreset(input logic strap, input logic up_n);
    @(posedge ref_clk);
    hard_reset_in <= 1'h1;
    cache_policy_strap <= strap;
    upgrade_present_n <= up_n;
    cyc(6);
    @(posedge ref_clk) hard_reset_in <= 1'h0;
    cyc(8);
  endtask : hreset

  task automatic t_regs();
    chk("voltage detect", 32'h0, {31'h0, voltage_detect_out});
    chk("write-through", 32'h1, {31'h0, fill_write_through});
    reg_r(8'h00);
    chk("ctrl reset", 32'h3, rd);
    reg_r(8'h0C);
    chk("unmapped", 32'h0, rd);
    reg_w(8'h00, 32'h0);
    reg_w(8'h04, 32'h1234_5000);
  endtask : t_regs

  task automatic t_soft_reset_in();
    @(posedge ref_clk) soft_reset_in <= 1'h1;
    cyc(4);
    @(posedge ref_clk) soft_reset_in <= 1'h0;
    cyc(4);
    chk("soft reset early", 32'h0, {31'h0, core_soft_reset});
    bnd();
    chk("soft reset", 32'h1, {31'h0, core_soft_reset});
    cyc(2);
    chk("controls", 32'h0, {30'h0, cache_disable_bit, no_writethrough_bit});
    chk("base", 32'h1234_5000, mgmt_base_pointer);
    chk("strap kept", 32'h1, {31'h0, fill_write_through});
  endtask : t_soft_reset_in

  task automatic t_bus();
    for (int w = 0; w < 2; w++) begin
      @(posedge ref_clk);
      use_burst <= w[0];
      core_cyc_start <= 1'h1;
      core_cyc <= {32'h0000_0100, 4'h0, 2'h3, w[0]};
      @(posedge ref_clk) core_cyc_start <= 1'h0;
      #1;
      wait_for(3);
      chk("write read", {31'h0, w[0]}, {31'h0, bus_cyc.write_read});
      wait_for(4);
    end
  endtask : t_bus

  task automatic t_mgmt();
    @(posedge ref_clk) sysmgmt_request_n <= 1'h0;
    cyc(6);
    bnd();
    chk("entry", 32'h1, {31'h0, core_smm_entry});
    chk("flag low", 32'h0, {31'h0, smm_active_n});
    @(posedge ref_clk);
    hold_ack <= 1'h1;
    backoff_n <= 1'h0;
    sysmgmt_request_n <= 1'h1;
    cyc(3);
    chk("flag driven", 32'h1, {31'h0, smm_active_oe});
    chk("flag held", 32'h0, {31'h0, smm_active_n});
    @(posedge ref_clk);
    hold_ack <= 1'h0;
    backoff_n <= 1'h1;
    rsm_exec <= 1'h1;
    @(posedge ref_clk) rsm_exec <= 1'h0;
    cyc(1);
    chk("flag released", 32'h1, {31'h0, smm_active_n});
  endtask : t_mgmt

  task automatic t_stop();
    @(posedge ref_clk) stp_go <= 1'h1;
    @(posedge ref_clk) stp_go <= 1'h0;
    cyc(6);
    irq_pending <= 1'h1;
    bnd();
    cyc(1);
    chk("halt over interrupt", 32'h0, {31'h0, core_halt});
    irq_pending <= 1'h0;
    bnd();
    wait_for(0);
    cyc(3);
    chk("no grant before drain", 32'h1, {31'h0, addr_strobe_n});
    drain_done <= 1'h1;
    wait_for(3);
    chk("grant addr", 32'h0000_0010, bus_cyc.addr);
    chk("grant type", 32'h59, {25'h0, bus_cyc[6:0]});
    wait_for(1);
    wait_for(2);
    chk("resume", 32'h1, {31'h0, core_resume});
    drain_done <= 1'h0;
  endtask : t_stop

  task automatic t_hard();
    @(posedge ref_clk) sysmgmt_request_n <= 1'h0;
    cyc(6);
    bnd();
    sysmgmt_request_n <= 1'h1;
    hreset(1'h1, 1'h0);
    chk("flag after reset", 32'h1, {31'h0, smm_active_n});
    chk("write-back", 32'h0, {31'h0, fill_write_through});
    chk("idle", 32'h1, {31'h0, core_inactive});
    chk("floated", 32'h0, {30'h0, bus_oe, smm_active_oe});
    upgrade_present_n <= 1'h1;
    cyc(8);
    chk("idle left", 32'h0, {31'h0, core_inactive});
    hreset(1'h0, 1'h1);
  endtask : t_hard

  initial begin
    cyc(5);
    rst_n <= 1'h1;
    hreset(1'h0, 1'h1);
    t_regs();
    t_soft_reset_in();
    t_bus();
    t_mgmt();
    t_stop();
    t_hard();
    end_of_test();
  end
endmodule : csc_sideband_ctrl_tb_top
